// >>> hw/rpa_pkg.sv
package rpa_pkg;
    // register command bytes (whole byte; bit 0 picks the register within a pair)
    localparam logic [7:0] CMD_IN0    = 8'h00;
    localparam logic [7:0] CMD_IN1    = 8'h01;
    localparam logic [7:0] CMD_OUT0   = 8'h02;
    localparam logic [7:0] CMD_OUT1   = 8'h03;
    localparam logic [7:0] CMD_POL0   = 8'h04;
    localparam logic [7:0] CMD_POL1   = 8'h05;
    localparam logic [7:0] CMD_CFG0   = 8'h06;
    localparam logic [7:0] CMD_CFG1   = 8'h07;
    localparam logic [7:0] CMD_DRV0A  = 8'h40;
    localparam logic [7:0] CMD_DRV0B  = 8'h41;
    localparam logic [7:0] CMD_DRV1A  = 8'h42;
    localparam logic [7:0] CMD_DRV1B  = 8'h43;
    localparam logic [7:0] CMD_LAT0   = 8'h44;
    localparam logic [7:0] CMD_LAT1   = 8'h45;
    localparam logic [7:0] CMD_PEN0   = 8'h46;
    localparam logic [7:0] CMD_PEN1   = 8'h47;
    localparam logic [7:0] CMD_PSEL0  = 8'h48;
    localparam logic [7:0] CMD_PSEL1  = 8'h49;
    localparam logic [7:0] CMD_MSK0   = 8'h4A;
    localparam logic [7:0] CMD_MSK1   = 8'h4B;
    localparam logic [7:0] CMD_STS0   = 8'h4C;
    localparam logic [7:0] CMD_STS1   = 8'h4D;
    localparam int         NUM_REGS   = 22;
    // reset values
    localparam logic [7:0] RST_OUT    = 8'hFF;
    localparam logic [7:0] RST_POL    = 8'h00;
    localparam logic [7:0] RST_CFG    = 8'hFF;
    localparam logic [7:0] RST_DRV    = 8'hFF;
    localparam logic [7:0] RST_LAT    = 8'h00;
    localparam logic [7:0] RST_PEN    = 8'h00;
    localparam logic [7:0] RST_PSEL   = 8'hFF;
    localparam logic [7:0] RST_MSK    = 8'hFF;
    localparam logic [7:0] RST_PTR    = 8'h00;
    // drive-strength codes, 2 bits per pin
    localparam logic [1:0] DRV_QUART  = 2'h0;
    localparam logic [1:0] DRV_HALF   = 2'h1;
    localparam logic [1:0] DRV_3QUART = 2'h2;
    localparam logic [1:0] DRV_FULL   = 2'h3;
    localparam int         NUM_FING   = 4;
    // bus address: 5-bit base, low two bits from strap pins
    localparam logic [4:0] ADDR_BASE  = 5'h1D;
    localparam logic       DIR_WRITE  = 1'b0;
    localparam logic       DIR_READ   = 1'b1;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_CMD  = 3'h2,
        ST_WDAT = 3'h3,
        ST_RDAT = 3'h4,
        ST_SKIP = 3'h5
    } rpa_state_t;
endpackage : rpa_pkg

// >>> hw/rpa_pad_drive.sv
`timescale 1ns/100ps
// per-pin output stage: finger enables for pull-up and pull-down legs
module rpa_pad_drive (
    input  wire logic       out_en_i,  // 1: pin is an output
    input  wire logic       data_i,    // output data bit
    input  wire logic       od_i,      // 1: open-drain, no pull-up leg
    input  wire logic [1:0] drv_i,     // drive-strength code
    output logic      [3:0] up_en_o,   // high-side fingers on
    output logic      [3:0] dn_en_o    // low-side fingers on
);
    logic [3:0] fingers;
    always_comb
    begin
        case (drv_i)
            rpa_pkg::DRV_QUART:  fingers = 4'h1;
            rpa_pkg::DRV_HALF:   fingers = 4'h3;
            rpa_pkg::DRV_3QUART: fingers = 4'h3;
            default:             fingers = 4'hF;
        endcase
        // code 10b: two fingers only
        if (drv_i == 2'h2)
        begin
            fingers = 4'h3;
        end
        else if (drv_i == 2'h1)
        begin
            fingers = 4'h7;
        end
        up_en_o = (out_en_i && data_i && !od_i) ? fingers : 4'h0;
        dn_en_o = (out_en_i && !data_i) ? fingers : 4'h0;
    end
endmodule : rpa_pad_drive

// >>> hw/rpa_target.sv
`timescale 1ns/100ps
module rpa_target #(
    parameter int W = 16                           // pin count
) (
    input  wire logic           clk_i,             // 10 MHz clock
    input  wire logic           rst_b_i,           // async reset, active low
    input  wire logic           scl_i,             // bus clock level
    input  wire logic           sda_i,             // bus data level
    output logic                sda_oe_b_o,        // low: pull sda low
    input  wire logic [1:0]     addr_sel_i,        // address strap pins
    input  wire logic [W-1:0]   pin_i,             // pin levels
    output logic      [W-1:0]   pin_out_o,         // output data per pin
    output logic      [W-1:0]   pin_is_out_o,      // 1: pin drives
    output logic      [4*W-1:0] up_en_o,           // high-side fingers
    output logic      [4*W-1:0] dn_en_o,           // low-side fingers
    output logic      [W-1:0]   pull_en_o,         // pull resistor on
    output logic      [W-1:0]   pull_up_o,         // 1: pull-up
    output logic                int_b_o            // low: change pending
);
    typedef struct packed {
        rpa_pkg::rpa_state_t st;
        logic                scl_d;
        logic                sda_d;
        logic [3:0]          bitn;
        logic [7:0]          shf;
        logic [7:0]          ptr;
        logic                ack_phase;
        logic                drive_low;
        logic                rd_mode;
        logic [7:0]          txb;
        logic [W-1:0]        outp;
        logic [W-1:0]        pol;
        logic [W-1:0]        cfg;
        logic [2*W-1:0]      drv;
        logic [W-1:0]        lat;
        logic [W-1:0]        pen;
        logic [W-1:0]        psel;
        logic [W-1:0]        msk;
        logic [W-1:0]        inreg;
        logic [W-1:0]        chg;
        logic [W-1:0]        snap;
        logic [1:0]          od;
    } rpa_s_t;

    rpa_s_t s;
    rpa_s_t next_s;
    logic   scl_rise;
    logic   scl_fall;
    logic   start_c;
    logic   stop_c;
    logic [7:0] rd_val;
    logic [W-1:0] in_now;
    logic [7:0] last_rd;

    assign scl_rise = scl_i && !s.scl_d;
    assign scl_fall = !scl_i && s.scl_d;
    assign start_c  = scl_i && s.scl_d && s.sda_d && !sda_i;
    assign stop_c   = scl_i && s.scl_d && !s.sda_d && sda_i;
    assign in_now   = pin_i ^ s.pol;
    assign last_rd  = {s.ptr[7:1], ~s.ptr[0]};

    // register read mux
    always_comb
    begin
        case (s.ptr)
            rpa_pkg::CMD_IN0:   rd_val = s.inreg[7:0];
            rpa_pkg::CMD_IN1:   rd_val = s.inreg[15:8];
            rpa_pkg::CMD_OUT0:  rd_val = s.outp[7:0];
            rpa_pkg::CMD_OUT1:  rd_val = s.outp[15:8];
            rpa_pkg::CMD_POL0:  rd_val = s.pol[7:0];
            rpa_pkg::CMD_POL1:  rd_val = s.pol[15:8];
            rpa_pkg::CMD_CFG0:  rd_val = s.cfg[7:0];
            rpa_pkg::CMD_CFG1:  rd_val = s.cfg[15:8];
            rpa_pkg::CMD_DRV0A: rd_val = s.drv[7:0];
            rpa_pkg::CMD_DRV0B: rd_val = s.drv[15:8];
            rpa_pkg::CMD_DRV1A: rd_val = s.drv[23:16];
            rpa_pkg::CMD_DRV1B: rd_val = s.drv[31:24];
            rpa_pkg::CMD_LAT0:  rd_val = s.lat[7:0];
            rpa_pkg::CMD_LAT1:  rd_val = s.lat[15:8];
            rpa_pkg::CMD_PEN0:  rd_val = s.pen[7:0];
            rpa_pkg::CMD_PEN1:  rd_val = s.pen[15:8];
            rpa_pkg::CMD_PSEL0: rd_val = s.psel[7:0];
            rpa_pkg::CMD_PSEL1: rd_val = s.psel[15:8];
            rpa_pkg::CMD_MSK0:  rd_val = s.msk[7:0];
            rpa_pkg::CMD_MSK1:  rd_val = s.msk[15:8];
            rpa_pkg::CMD_STS0:  rd_val = s.chg[7:0] & ~s.msk[7:0];
            rpa_pkg::CMD_STS1:  rd_val = s.chg[15:8] & ~s.msk[15:8];
            default:            rd_val = 8'h00;
        endcase
    end

    always_comb
    begin
        next_s       = s;
        next_s.scl_d = scl_i;
        next_s.sda_d = sda_i;
        // change is against the value last read; latched pins hold it until read
        for (int i = 0; i < W; i++)
        begin
            if (s.cfg[i] && (in_now[i] != s.snap[i]))
            begin
                next_s.chg[i] = 1'b1;
            end
            else if (!s.lat[i])
            begin
                next_s.chg[i] = 1'b0;
            end
            if (!s.lat[i] || !s.chg[i])
            begin
                next_s.inreg[i] = in_now[i];
            end
        end
        if (stop_c)
        begin
            next_s.st        = rpa_pkg::ST_IDLE;
            next_s.drive_low = 1'b0;
            next_s.ack_phase = 1'b0;
        end
        else if (start_c)
        begin
            next_s.st        = rpa_pkg::ST_ADDR;
            next_s.bitn      = 4'h0;
            next_s.drive_low = 1'b0;
            next_s.ack_phase = 1'b0;
        end
        else if (scl_rise && !s.ack_phase && s.st != rpa_pkg::ST_IDLE)
        begin
            next_s.shf  = {s.shf[6:0], sda_i};
            next_s.bitn = s.bitn + 4'h1;
        end
        else if (scl_rise && s.ack_phase && s.rd_mode)
        begin
            // master ack sampled; nack ends our transmission
            if (sda_i)
            begin
                next_s.st = rpa_pkg::ST_SKIP;
            end
            // data ack only: pointer already moved past the port just sent
            if (s.st == rpa_pkg::ST_RDAT && !s.drive_low && last_rd == rpa_pkg::CMD_IN0)
            begin
                next_s.chg[7:0]  = 8'h00;
                next_s.snap[7:0] = s.inreg[7:0];
            end
            else if (s.st == rpa_pkg::ST_RDAT && !s.drive_low && last_rd == rpa_pkg::CMD_IN1)
            begin
                next_s.chg[15:8]  = 8'h00;
                next_s.snap[15:8] = s.inreg[15:8];
            end
        end
        else if (scl_fall)
        begin
            if (s.ack_phase)
            begin
                next_s.ack_phase = 1'b0;
                next_s.drive_low = 1'b0;
                next_s.bitn      = 4'h0;
                if (s.rd_mode && s.st == rpa_pkg::ST_RDAT)
                begin
                    next_s.txb       = rd_val;
                    next_s.ptr       = {s.ptr[7:1], ~s.ptr[0]};
                    next_s.drive_low = !rd_val[7];
                end
            end
            else if (s.rd_mode && s.st == rpa_pkg::ST_RDAT && s.bitn != 4'h8)
            begin
                next_s.drive_low = !s.txb[3'h7 - s.bitn[2:0]];
            end
            else if (s.bitn == 4'h8)
            begin
                next_s.ack_phase = 1'b1;
                next_s.drive_low = 1'b0;
                case (s.st)
                    rpa_pkg::ST_ADDR:
                    begin
                        if (s.shf[7:1] == {rpa_pkg::ADDR_BASE, addr_sel_i})
                        begin
                            next_s.drive_low = 1'b1;
                            next_s.rd_mode   = s.shf[0];
                            next_s.st = (s.shf[0] == rpa_pkg::DIR_READ) ?
                                        rpa_pkg::ST_RDAT : rpa_pkg::ST_CMD;
                        end
                        else
                        begin
                            next_s.st = rpa_pkg::ST_SKIP;
                        end
                    end
                    rpa_pkg::ST_CMD:
                    begin
                        next_s.ptr       = s.shf;
                        next_s.drive_low = 1'b1;
                        next_s.st        = rpa_pkg::ST_WDAT;
                    end
                    rpa_pkg::ST_WDAT:
                    begin
                        next_s.drive_low = 1'b1;
                        next_s.ptr = {s.ptr[7:1], ~s.ptr[0]};
                        case (s.ptr)
                            rpa_pkg::CMD_OUT0:  next_s.outp[7:0]   = s.shf;
                            rpa_pkg::CMD_OUT1:  next_s.outp[15:8]  = s.shf;
                            rpa_pkg::CMD_POL0:  next_s.pol[7:0]    = s.shf;
                            rpa_pkg::CMD_POL1:  next_s.pol[15:8]   = s.shf;
                            rpa_pkg::CMD_CFG0:  next_s.cfg[7:0]    = s.shf;
                            rpa_pkg::CMD_CFG1:  next_s.cfg[15:8]   = s.shf;
                            rpa_pkg::CMD_DRV0A: next_s.drv[7:0]    = s.shf;
                            rpa_pkg::CMD_DRV0B: next_s.drv[15:8]   = s.shf;
                            rpa_pkg::CMD_DRV1A: next_s.drv[23:16]  = s.shf;
                            rpa_pkg::CMD_DRV1B: next_s.drv[31:24]  = s.shf;
                            rpa_pkg::CMD_LAT0:  next_s.lat[7:0]    = s.shf;
                            rpa_pkg::CMD_LAT1:  next_s.lat[15:8]   = s.shf;
                            rpa_pkg::CMD_PEN0:  next_s.pen[7:0]    = s.shf;
                            rpa_pkg::CMD_PEN1:  next_s.pen[15:8]   = s.shf;
                            rpa_pkg::CMD_PSEL0: next_s.psel[7:0]   = s.shf;
                            rpa_pkg::CMD_PSEL1: next_s.psel[15:8]  = s.shf;
                            rpa_pkg::CMD_MSK0:  next_s.msk[7:0]    = s.shf;
                            rpa_pkg::CMD_MSK1:  next_s.msk[15:8]   = s.shf;
                            default:            next_s.ptr = next_s.ptr;
                        endcase
                    end
                    rpa_pkg::ST_RDAT:
                    begin
                        next_s.drive_low = 1'b0;
                    end
                    default:
                    begin
                        next_s.st = rpa_pkg::ST_SKIP;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s           <= '0;
            s.st        <= rpa_pkg::ST_IDLE;
            s.scl_d     <= 1'b1;
            s.sda_d     <= 1'b1;
            s.ptr       <= rpa_pkg::RST_PTR;
            s.outp      <= {2{rpa_pkg::RST_OUT}};
            s.pol       <= {2{rpa_pkg::RST_POL}};
            s.cfg       <= {2{rpa_pkg::RST_CFG}};
            s.drv       <= {4{rpa_pkg::RST_DRV}};
            s.lat       <= {2{rpa_pkg::RST_LAT}};
            s.pen       <= {2{rpa_pkg::RST_PEN}};
            s.psel      <= {2{rpa_pkg::RST_PSEL}};
            s.msk       <= {2{rpa_pkg::RST_MSK}};
        end
        else
        begin
            s <= next_s;
        end
    end

    for (genvar g = 0; g < W; g++)
    begin : g_pad
        rpa_pad_drive u_pad (
            .out_en_i (!s.cfg[g]),
            .data_i   (s.outp[g]),
            .od_i     (s.od[g / 8]),
            .drv_i    (s.drv[2*g +: 2]),
            .up_en_o  (up_en_o[4*g +: 4]),
            .dn_en_o  (dn_en_o[4*g +: 4])
        );
    end

    assign sda_oe_b_o   = !s.drive_low;
    assign pin_out_o    = s.outp;
    assign pin_is_out_o = ~s.cfg;
    assign pull_en_o    = s.pen;
    assign pull_up_o    = s.psel;
    assign int_b_o      = !(|(s.chg & ~s.msk & s.cfg));
endmodule : rpa_target

// >>> tb/rpa_properties.sv
`timescale 1ns/100ps
module rpa_checker #(
    parameter int W = 16                       // pin count
) (
    input  wire logic           clk_i,         // clock
    input  wire logic           rst_b_i,       // reset, active low
    input  wire logic           scl_i,         // bus clock
    input  wire logic           sda_i,         // bus data
    input  wire logic           sda_oe_b_o,    // low: data pulled
    input  wire logic [1:0]     addr_sel_i,    // address straps
    input  wire logic [W-1:0]   pin_i,         // pin levels
    input  wire logic [W-1:0]   pin_out_o,     // output data
    input  wire logic [W-1:0]   pin_is_out_o,  // direction
    input  wire logic [4*W-1:0] up_en_o,       // high fingers
    input  wire logic [4*W-1:0] dn_en_o,       // low fingers
    input  wire logic [W-1:0]   pull_en_o,     // pull on
    input  wire logic [W-1:0]   pull_up_o,     // pull-up select
    input  wire logic           int_b_o        // low: change pending
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sda_drive_a: assert property ($fell(sda_oe_b_o) |-> !scl_i)
        else $error("data pulled while clock high");
    sda_free_a: assert property ($rose(sda_oe_b_o) |-> !scl_i)
        else $error("data released while clock high");
    out_store_a: assert property ($changed(pin_out_o) |-> !scl_i)
        else $error("output data changed outside ack phase");
    dir_store_a: assert property ($changed(pin_is_out_o) |-> !scl_i)
        else $error("direction changed outside ack phase");
    pull_store_a: assert property ($changed(pull_en_o) || $changed(pull_up_o) |-> !scl_i)
        else $error("pull setting changed outside ack phase");
    rst_dflt_a: assert property ($rose(rst_b_i) |-> pin_out_o == '1 && pin_is_out_o == '0
        && pull_en_o == '0 && int_b_o && sda_oe_b_o)
        else $error("defaults missing after reset");
    legs_excl_a: assert property ((up_en_o & dn_en_o) == '0)
        else $error("both legs on");
    in_idle_a: assert property (!pin_is_out_o[0] |-> up_en_o[3:0] == 4'h0
        && dn_en_o[3:0] == 4'h0)
        else $error("input pin drives");
    high_leg_a: assert property (pin_is_out_o[0] && pin_out_o[0] |-> dn_en_o[3:0] == 4'h0
        && up_en_o[3:0] != 4'h0)
        else $error("high output not on high leg");

    cover property ($fell(sda_oe_b_o));
    cover property ($changed(pin_out_o));
    cover property ($fell(int_b_o));
endmodule : rpa_checker

bind rpa_target rpa_checker #(.W(W)) i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_oe_b_o(sda_oe_b_o), .addr_sel_i(addr_sel_i), .pin_i(pin_i),
    .pin_out_o(pin_out_o), .pin_is_out_o(pin_is_out_o), .up_en_o(up_en_o), .dn_en_o(dn_en_o),
    .pull_en_o(pull_en_o), .pull_up_o(pull_up_o), .int_b_o(int_b_o));

// >>> tb/rpa_master.sv
`timescale 1ns/100ps
module rpa_master (
    input  wire logic clk_i,  // bench clock
    input  wire logic sda_i,  // resolved data line
    output logic      scl_o,  // bus clock, idle high
    output logic      sda_o   // low: pull data, else released
);
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick();
        repeat (4) @(negedge clk_i);
    endtask : tick
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        tick();
        scl_o = 1'b1;
        tick();
        tick();
        r     = sda_i;
        scl_o = 1'b0;
        tick();
    endtask : bit_io
    // also serves as repeated start
    task automatic start();
        sda_o = 1'b1;
        tick();
        scl_o = 1'b1;
        tick();
        sda_o = 1'b0;
        tick();
        scl_o = 1'b0;
        tick();
    endtask : start
    task automatic stop();
        sda_o = 1'b0;
        tick();
        scl_o = 1'b1;
        tick();
        sda_o = 1'b1;
        tick();
    endtask : stop
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : put
    task automatic get(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(nack, r);
    endtask : get
endmodule : rpa_master

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    typedef struct packed {
        logic [7:0] c;
        logic [7:0] a;
        logic [7:0] b;
    } rpa_row_t;
    logic        clk_i, rst_b_i, scl_m, sda_m, sda_oe_b_o, int_b_o, k;
    logic [1:0]  addr_sel_i;
    logic [15:0] pin_i, pin_out_o, pin_is_out_o, pull_en_o, pull_up_o;
    logic [63:0] up_en_o, dn_en_o;
    logic [7:0]  rbuf [0:3];
    logic [3:0]  on_leg, off_leg;
    logic [15:0] fin [4] = '{16'h1, 16'h3, 16'h2, 16'h4};
    int          num_errors, n_compared;
    wire         sda_w = sda_m & sda_oe_b_o;
    wire  [7:0]  adr_w = {rpa_pkg::ADDR_BASE, addr_sel_i, rpa_pkg::DIR_WRITE};
    wire  [7:0]  adr_r = {rpa_pkg::ADDR_BASE, addr_sel_i, rpa_pkg::DIR_READ};
    rpa_row_t    rows [8] = '{
        '{rpa_pkg::CMD_OUT1, 8'h81, 8'h7E}, '{rpa_pkg::CMD_POL1, 8'hA5, 8'h00},
        '{rpa_pkg::CMD_CFG1, 8'h0F, 8'hFF}, '{rpa_pkg::CMD_DRV0A, 8'h1B, 8'hC6},
        '{rpa_pkg::CMD_DRV1B, 8'h55, 8'hAA}, '{rpa_pkg::CMD_PEN1, 8'h3C, 8'hC3},
        '{rpa_pkg::CMD_PSEL0, 8'h0F, 8'hF0}, '{rpa_pkg::CMD_MSK1, 8'hFF, 8'hFE}};

    rpa_target #(.W(16)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_m), .sda_i(sda_w),
        .sda_oe_b_o(sda_oe_b_o), .addr_sel_i(addr_sel_i), .pin_i(pin_i), .pin_out_o(pin_out_o),
        .pin_is_out_o(pin_is_out_o), .up_en_o(up_en_o), .dn_en_o(dn_en_o),
        .pull_en_o(pull_en_o), .pull_up_o(pull_up_o), .int_b_o(int_b_o));
    rpa_master i_mst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_m), .sda_o(sda_m));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic open_cmd(input logic [7:0] c);
        i_mst.start();
        i_mst.put(adr_w, k);
        chk(k, 1'b1);
        i_mst.put(c, k);
    endtask : open_cmd
    task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b);
        open_cmd(c);
        i_mst.put(a, k);
        i_mst.put(b, k);
        chk(k, 1'b1);
        i_mst.stop();
    endtask : wr
    task automatic rd_more(input int n);
        i_mst.start();
        i_mst.put(adr_r, k);
        for (int i = 0; i < n; i++)
            i_mst.get(i == n - 1, rbuf[i]);
    endtask : rd_more
    task automatic rd(input logic [7:0] c, input int n);
        open_cmd(c);
        rd_more(n);
        i_mst.stop();
    endtask : rd
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial
    begin
        #8_000_000;
        num_errors++;
        complete_run();
    end
    initial
    begin
        rst_b_i    = 1'b0;
        pin_i      = 16'h0000;
        addr_sel_i = 2'h2;
        num_errors = 0;
        n_compared = 0;
        repeat (10) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk(pin_out_o, 16'hFFFF);
        chk(pin_is_out_o, 16'h0000);
        chk(pull_en_o ^ pull_up_o, 16'hFFFF);
        chk({int_b_o, sda_oe_b_o}, 2'h3);
        rd(rpa_pkg::CMD_MSK0, 2);
        chk({rbuf[0], rbuf[1]}, 16'hFFFF);
        foreach (rows[r])
        begin
            wr(rows[r].c, rows[r].a, rows[r].b);
            rd(rows[r].c, 3);
            chk(rbuf[0], rows[r].a);
            chk(rbuf[1], rows[r].b);
            chk(rbuf[2], rows[r].a);
        end
        chk(pin_out_o, 16'h817E);
        chk(pin_is_out_o, 16'hF000);
        chk(pull_en_o, 16'h3CC3);
        chk(pull_up_o, 16'hF00F);
        // unmasked input change, then cleared by reading its port
        pin_i = 16'h0001;
        repeat (20) @(negedge clk_i);
        chk(int_b_o, 1'b0);
        rd(rpa_pkg::CMD_STS0, 1);
        chk(rbuf[0], 8'h01);
        rd(rpa_pkg::CMD_IN0, 1);
        chk(rbuf[0], 8'h01);
        chk(int_b_o, 1'b1);
        open_cmd(rpa_pkg::CMD_OUT1);
        rd_more(1);
        chk(rbuf[0], 8'h81);
        rd_more(1);
        chk(rbuf[0], 8'h7E);
        rd_more(2);
        chk({rbuf[0], rbuf[1]}, 16'h817E);
        i_mst.stop();
        // wrong address is not acknowledged
        i_mst.start();
        i_mst.put(adr_w ^ 8'h02, k);
        chk(k, 1'b0);
        i_mst.stop();
        open_cmd(rpa_pkg::CMD_OUT0);
        i_mst.put(8'h3C, k);
        repeat (4) i_mst.bit_io(1'b0, k);
        i_mst.stop();
        chk(pin_out_o, 16'h813C);
        wr(rpa_pkg::CMD_OUT0, 8'h5A, 8'h81);
        wr(rpa_pkg::CMD_DRV0A, 8'hE4, 8'hC6);
        wr(rpa_pkg::CMD_CFG0, 8'h00, 8'h0F);
        chk(pin_out_o, 16'h815A);
        chk(pin_is_out_o, 16'hF0FF);
        chk(16'(up_en_o[35:32] | dn_en_o[35:32]), 16'h0);
        for (int p = 0; p < 4; p++)
        begin
            on_leg  = pin_out_o[p] ? up_en_o[4*p+:4] : dn_en_o[4*p+:4];
            off_leg = pin_out_o[p] ? dn_en_o[4*p+:4] : up_en_o[4*p+:4];
            chk(16'($countones(on_leg)), fin[p]);
            chk(16'(off_leg), 16'h0);
        end
        rst_b_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk(pin_out_o, 16'hFFFF);
        chk(pin_is_out_o, 16'h0000);
        complete_run();
    end
endmodule : testbench
